// ### hdl/sbus_timing.sv
// Clock timing, SDA setup/hold, timeouts and configuration of the serial bus
// Summary of operation
// - As master with a free SCL the bit rate is about the source overflow rate over three.
// - A master SCL low phase ends before its minimum overflow count only when enable is cleared; a high phase ends early when another device pulls SCL low.
// - Without extension SDA setup is about Tlow less four clocks and hold is three clocks.
// - With extension SDA is stable eleven clocks before SCL rises and twelve after it falls.
// - Setup counts SDA stable before SCL rises and hold counts SDA stable after SCL falls.
// - With low timeout enabled the timeout timer reloads while SCL is high and counts when low.
// - With free timeout enabled the bus is free after both lines stay high over ten periods.
// - The master follows the real SCL level so stretching and contention are tolerated.
// - The configuration register holds enable, inhibit, busy, extension, timeouts, source.
// - The source field picks timer 0, timer 1, timer 2 high or timer 2 low overflow.
// - Minimum SCL low lasts one and maximum high two overflow periods of the selected source.
// - A pending master start is issued right after the free timeout expires.
`timescale 1ns/1ps
module sbus_timing
    import sbus_timing_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire sfr_req_t   sfr_req,
    output logic [7:0]      sfr_rdata,
    input  wire logic [3:0] timer_ovf,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    input  wire logic       master_active,
    input  wire logic       start_pending,
    input  wire logic       sda_next,
    input  wire logic       transfer_end,
    output logic            scl_out,
    output logic            scl_oe,
    output logic            sda_out,
    output logic            sda_oe,
    output logic            timeout_reload,
    output logic            start_go,
    output logic            slave_inhibit,
    output logic            interface_enable_bit
);

    // Complete block state in one record
    typedef struct packed {
        cfg_t        cfg;
        logic [1:0]  scl_sy;
        logic [1:0]  sda_sy;
        scl_state_t  st;
        logic [1:0]  ovf_cnt;
        logic [3:0]  free_cnt;
        logic [3:0]  hold_cnt;
        logic [3:0]  setup_cnt;
        logic        sda_q;
        logic        sda_pend;
        logic        scl_prev;
        logic [7:0]  rdata;
        logic        scl_drv_low;
        logic        sda_drv_low;
        logic        reload;
        logic        start;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic   ovf;
    logic   scl_s;
    logic   sda_s;

    function automatic logic pick_ovf(input logic [1:0] cs, input logic [3:0] ov);
        pick_ovf = ov[cs];
    endfunction : pick_ovf

    assign ovf   = pick_ovf(s_q.cfg.clk_src, timer_ovf);
    assign scl_s = s_q.scl_sy[1];
    assign sda_s = s_q.sda_sy[1];

    // Next state of the whole block
    always_comb begin
        s_d        = s_q;
        s_d.start  = 1'b0;
        // Pins pass two flops before use
        s_d.scl_sy = {s_q.scl_sy[0], scl_in};
        s_d.sda_sy = {s_q.sda_sy[0], sda_in};
        s_d.scl_prev = scl_s;

        if (sfr_req.wr && sfr_req.addr == CFG_ADDR) begin
            s_d.cfg.enable     = sfr_req.wdata[BIT_ENABLE];
            s_d.cfg.inhibit    = sfr_req.wdata[BIT_INHIBIT];
            s_d.cfg.hold_ext   = sfr_req.wdata[BIT_HOLD_EXT];
            s_d.cfg.low_to_en  = sfr_req.wdata[BIT_LOW_TO_EN];
            s_d.cfg.free_to_en = sfr_req.wdata[BIT_FREE_TO_EN];
            s_d.cfg.clk_src    = sfr_req.wdata[BIT_CS_HI:BIT_CS_LO];
        end
        s_d.rdata = (sfr_req.addr == CFG_ADDR) ? s_q.cfg : 8'h00;

        // Busy while a transfer runs; set wins over clear
        if (master_active || (scl_s == 1'b0))
            s_d.cfg.busy = 1'b1;
        else if (transfer_end)
            s_d.cfg.busy = 1'b0;

        // free timeout counts source periods with both lines high
        if (!(scl_s && sda_s) || !s_q.cfg.free_to_en) begin
            s_d.free_cnt = 4'h0;
        end else if (ovf && s_q.free_cnt <= FREE_PERIODS) begin
            s_d.free_cnt = s_q.free_cnt + 4'h1;
        end
        if (s_q.cfg.free_to_en && ovf && s_q.free_cnt == FREE_PERIODS && scl_s && sda_s) begin
            // Timeout clears busy, but a running master keeps it set
            s_d.cfg.busy = master_active;
            s_d.start    = start_pending && s_q.cfg.enable;
        end

        // timeout timer reloads while SCL high
        s_d.reload = s_q.cfg.low_to_en && scl_s;

        // master SCL generation tracking real SCL
        case (s_q.st)
            ST_IDLE: begin
                s_d.ovf_cnt     = 2'h0;
                s_d.scl_drv_low = 1'b0;
                if (master_active && s_q.cfg.enable) begin
                    s_d.st          = ST_LOW;
                    s_d.scl_drv_low = 1'b1;
                end
            end
            ST_LOW: begin
                // Saturate so a long stretch cannot wrap below the minimum
                if (ovf && s_q.ovf_cnt != 2'h3)
                    s_d.ovf_cnt = s_q.ovf_cnt + 2'h1;
                // release only once setup is met
                if ((s_q.ovf_cnt >= LOW_PERIODS) && !s_q.sda_pend &&
                    s_q.setup_cnt >= (s_q.cfg.hold_ext ? SETUP_EXT_CLKS : SETUP_STD_CLKS)) begin
                    s_d.scl_drv_low = 1'b0;
                    // wait for real SCL high before timing high phase
                    if (scl_s) begin
                        s_d.st      = ST_HIGH;
                        s_d.ovf_cnt = 2'h0;
                    end
                end
            end
            ST_HIGH: begin
                // Saturating overflow count of the high phase
                if (ovf && s_q.ovf_cnt != 2'h3)
                    s_d.ovf_cnt = s_q.ovf_cnt + 2'h1;
                if (!master_active || !s_q.cfg.enable) begin
                    s_d.st = ST_IDLE;
                end else if (!scl_s) begin
                    // another device pulled SCL low: follow it
                    s_d.st          = ST_LOW;
                    s_d.ovf_cnt     = 2'h0;
                    s_d.scl_drv_low = 1'b1;
                end else if (s_q.ovf_cnt >= HIGH_PERIODS) begin
                    s_d.st          = ST_LOW;
                    s_d.ovf_cnt     = 2'h0;
                    s_d.scl_drv_low = 1'b1;
                end
            end
            default: s_d.st = ST_IDLE;
        endcase

        // hold counter restarts on SCL falling edge
        if (s_q.scl_prev && !scl_s)
            s_d.hold_cnt = 4'h0;
        else if (s_q.hold_cnt != 4'hf)
            s_d.hold_cnt = s_q.hold_cnt + 4'h1;

        // SDA changes only after the hold time passes
        // Moves only while we still pull SCL low: once released, a change eats setup
        // The SCL fall cycle is skipped since the hold count restarts there
        // An idle master may move SDA at once: start and stop belong to the shifter
        if (sda_next != s_q.sda_q)
            s_d.sda_pend = 1'b1;
        if (s_q.sda_pend && (
            (s_q.st == ST_IDLE && !master_active) ||
            (s_q.scl_drv_low && !scl_s && !s_q.scl_prev &&
             s_q.hold_cnt >= (s_q.cfg.hold_ext ? HOLD_EXT_CLKS : HOLD_STD_CLKS)))) begin
            s_d.sda_q     = sda_next;
            s_d.sda_pend  = 1'b0;
            s_d.setup_cnt = 4'h0;
        end else if (s_q.setup_cnt != 4'hf) begin
            s_d.setup_cnt = s_q.setup_cnt + 4'h1;
        end

        if (!s_q.cfg.enable) begin
            s_d.st          = ST_IDLE;
            s_d.scl_drv_low = 1'b0;
        end

        // Registered so the SDA enable comes straight from a flop
        s_d.sda_drv_low = !s_d.sda_q && s_d.cfg.enable;
    end

    // Single state register
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_q       <= '0;
            s_q.sda_q <= 1'b1;
            s_q.setup_cnt <= 4'hf;
            s_q.hold_cnt  <= 4'hf;
            // Synchronisers start at the pulled-up idle level; a low start
            // would look like a bus falling edge and set busy after reset
            s_q.scl_sy    <= 2'h3;
            s_q.sda_sy    <= 2'h3;
            s_q.scl_prev  <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from state flops, scl_out and sda_out tied low; open drain drives low only
    assign sfr_rdata            = s_q.rdata;
    assign scl_out              = 1'b0;
    assign scl_oe               = s_q.scl_drv_low;
    assign sda_out              = 1'b0;
    assign sda_oe               = s_q.sda_drv_low;
    assign timeout_reload       = s_q.reload;
    assign start_go             = s_q.start;
    assign slave_inhibit        = s_q.cfg.inhibit;
    assign interface_enable_bit = s_q.cfg.enable;

endmodule : sbus_timing

// ### hdl/sbus_timing_pkg.sv
// Package of constants and carriers for the serial bus timing and configuration block
package sbus_timing_pkg;

    // Special function register address of the configuration register
    localparam logic [7:0] CFG_ADDR       = 8'hc1;
    localparam logic [7:0] CFG_RESET      = 8'h00;

    // Field positions inside the configuration register
    localparam int         BIT_ENABLE     = 7;
    localparam int         BIT_INHIBIT    = 6;
    localparam int         BIT_BUSY       = 5;
    localparam int         BIT_HOLD_EXT   = 4;
    localparam int         BIT_LOW_TO_EN  = 3;
    localparam int         BIT_FREE_TO_EN = 2;
    localparam int         BIT_CS_HI      = 1;
    localparam int         BIT_CS_LO      = 0;

    // Clock source encodings
    localparam logic [1:0] CS_TIMER0      = 2'h0;
    localparam logic [1:0] CS_TIMER1      = 2'h1;
    localparam logic [1:0] CS_TIMER2_HI   = 2'h2;
    localparam logic [1:0] CS_TIMER2_LO   = 2'h3;

    // SDA timing counts in system clocks
    localparam logic [3:0] SETUP_EXT_CLKS = 4'hb;
    localparam logic [3:0] HOLD_EXT_CLKS  = 4'hc;
    localparam logic [3:0] HOLD_STD_CLKS  = 4'h3;
    localparam logic [3:0] SETUP_STD_CLKS = 4'h1;
    // Free timeout: more than this many clock-source periods
    localparam logic [3:0] FREE_PERIODS   = 4'ha;
    // High phase lasts two overflow periods, low one
    localparam logic [1:0] HIGH_PERIODS   = 2'h2;
    localparam logic [1:0] LOW_PERIODS    = 2'h1;

    // Configuration register fields
    typedef struct packed {
        logic       enable;
        logic       inhibit;
        logic       busy;
        logic       hold_ext;
        logic       low_to_en;
        logic       free_to_en;
        logic [1:0] clk_src;
    } cfg_t;

    // Register access port of the special function register bus
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic [7:0] wdata;
    } sfr_req_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LOW,
        ST_HIGH
    } scl_state_t;

endpackage : sbus_timing_pkg

// ### sim/sbus_bus_model.sv
// Far side of the bus: pull-ups, other drivers and a clock-stretching slave
`timescale 1ns/1ps
module sbus_bus_model (
    input  wire logic core_clk,
    input  wire logic scl_oe,
    input  wire logic sda_oe,
    input  wire logic stretch_en,
    input  wire logic scl_hold,
    output logic      scl,
    output logic      sda
);
    logic [5:0] str_q = 6'h00;
    // slave stretches SCL
    // Slow slave keeps SCL low 63 clocks after each pull, past the next overflow
    always_ff @(posedge core_clk) begin
        if (stretch_en && $rose(scl_oe)) str_q <= 6'h3f;
        else if (str_q != 6'h00) str_q <= str_q - 6'h01;
    end
    // Wired AND: a released line is pulled high
    assign scl = !(scl_oe || scl_hold || str_q != 6'h00);
    assign sda = !sda_oe;
endmodule : sbus_bus_model

// ### sim/sbus_timing_properties.sv
// Port checks of the serial bus timing block
`timescale 1ns/1ps
module sbus_timing_properties
    import sbus_timing_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       rstn,
    input wire sfr_req_t   sfr_req,
    input wire logic [7:0] sfr_rdata,
    input wire logic [3:0] timer_ovf,
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       master_active,
    input wire logic       start_pending,
    input wire logic       scl_oe,
    input wire logic       sda_oe,
    input wire logic       timeout_reload,
    input wire logic       start_go,
    input wire logic       slave_inhibit,
    input wire logic       interface_enable_bit
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    logic ovf_q;
    // Overflow seen while we pull SCL; any source, the bench drives one
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) ovf_q <= 1'b0;
        else ovf_q <= scl_oe && (ovf_q || |timer_ovf);
    end
    // SDA frozen at the SCL pull and two clocks after
    sequence s_hold;
        $stable(sda_oe)[*3];
    endsequence
    AST_LOW_MIN: assert property ($fell(scl_oe) && master_active |-> ovf_q)
        else $error("scl low ended early");
    AST_HOLD: assert property ($rose(scl_oe) |-> s_hold)
        else $error("sda hold short");
    AST_SETUP: assert property ($fell(scl_oe) |-> $stable(sda_oe))
        else $error("sda setup short");
    AST_RELOAD: assert property ((!scl_in)[*5] |-> !timeout_reload)
        else $error("reload while scl low");
    AST_WR_CFG: assert property (sfr_req.wr && sfr_req.addr == CFG_ADDR |=>
        {interface_enable_bit, slave_inhibit} == $past(sfr_req.wdata[7:6]))
        else $error("config write lost");
    AST_RD_OTHER: assert property (sfr_req.addr != CFG_ADDR |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_START_PULSE: assert property (start_go |-> $past(start_pending) ##1 !start_go)
        else $error("bad start pulse");
    AST_FREE_LINES: assert property (start_go |-> $past(scl_in, 4) && $past(sda_in, 4))
        else $error("start on busy bus");
endmodule : sbus_timing_properties
bind sbus_timing sbus_timing_properties sbus_timing_properties_i (.*);

// ### sim/sbus_timing_tb.sv
// Random and directed bench for the serial bus timing block
`timescale 1ns/1ps
module sbus_timing_tb;
    import sbus_timing_pkg::*;
    logic       core_clk, rstn, scl, sda, stretch_en, scl_hold, master_active;
    logic       start_pending, sda_next, transfer_end, scl_oe, sda_oe, start_go;
    logic       timeout_reload, p_scl, p_sda;
    logic       slave_inhibit, interface_enable_bit, scl_out, sda_out;
    logic [7:0] sfr_rdata, v;
    logic [3:0] timer_ovf;
    sfr_req_t   sfr_req;
    int         seed = 31, bad_count = 0, num_checks = 0, sel, per = 32, tk;
    int         hc, sc, mh, ms, rs, n;
    sbus_timing sbus_timing_i (.core_clk, .rstn, .sfr_req, .sfr_rdata, .timer_ovf,
        .scl_in(scl), .sda_in(sda), .master_active, .start_pending, .sda_next,
        .transfer_end, .scl_out, .scl_oe, .sda_out, .sda_oe, .timeout_reload,
        .start_go, .slave_inhibit, .interface_enable_bit);
    sbus_bus_model sbus_bus_model_i (.core_clk, .scl_oe, .sda_oe, .stretch_en,
        .scl_hold, .scl, .sda);
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // One overflow source, random data bit, hold/setup and SCL pull monitor
    always @(negedge core_clk) begin
        tk = (tk + 1) % per;
        timer_ovf = (tk == 0) ? 4'h1 << sel : 4'h0;
        // New data bit at each SCL pull; an idle master asks for a released SDA
        if (!master_active) sda_next = 1'b1;
        else if (scl_oe && !p_scl) sda_next = $random(seed);
        hc = !scl_oe ? 0 : (p_scl ? hc + 1 : 1);
        sc = (sda_oe !== p_sda) ? 0 : sc + 1;
        if (master_active && scl_oe && sda_oe !== p_sda && hc - 1 < mh) mh = hc - 1;
        if (master_active && !scl_oe && p_scl && sc < ms) ms = sc;
        rs = rs + int'(scl_oe && !p_scl);
        p_scl = scl_oe;
        p_sda = sda_oe;
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk) sfr_req = '{a, 1'b1, d};
        @(negedge core_clk) sfr_req.wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(negedge core_clk) sfr_req = '{a, 1'b0, 8'h00};
        @(negedge core_clk) v = sfr_rdata;
    endtask : rd
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    initial begin
        rstn = 1'b0;
        sfr_req = '0;
        timer_ovf = 4'h0;
        {master_active, start_pending, sda_next, transfer_end, stretch_en, scl_hold} = '0;
        repeat (16) @(posedge core_clk);
        @(negedge core_clk) rstn = 1'b1;
        rd(CFG_ADDR);
        chk("cfg reset", CFG_RESET, v);
        // Random writes; busy reads zero on an idle bus
        for (int i = 0; i < 6; i++) begin
            n = $random(seed);
            wr(CFG_ADDR, n[7:0]);
            rd(CFG_ADDR);
            chk("cfg rw", n[7:0] & 8'hdf, v);
            chk("pins", {6'h00, n[6], n[7]}, {6'h00, slave_inhibit, interface_enable_bit});
        end
        wr(8'hc2, 8'hff);
        rd(8'hc2);
        chk("unmapped", 8'h00, v);
        chk("open drain", 8'h00, {6'h00, scl_out, sda_out});
        // Reload follows SCL while enabled; SCL low marks busy
        wr(CFG_ADDR, 8'h88);
        repeat (5) @(negedge core_clk);
        chk("reload high", 8'h01, 8'(timeout_reload));
        scl_hold = 1'b1;
        repeat (6) @(negedge core_clk);
        chk("reload low", 8'h00, 8'(timeout_reload));
        rd(CFG_ADDR);
        chk("busy", 8'ha8, v);
        // long low stands for a timeout; recover by enable toggle
        wr(CFG_ADDR, 8'h08);
        chk("enable off", 8'h00, 8'(interface_enable_bit));
        wr(CFG_ADDR, 8'h88);
        chk("enable on", 8'h01, 8'(interface_enable_bit));
        scl_hold = 1'b0;
        $display("test registers done");
        // Each source, sources 1 and 3 with extension, first without and then with a stretching slave
        for (int k = 0; k < 8; k++) begin
            sel = k % 4;
            stretch_en = k > 3;
            mh = 99;
            ms = 99;
            // extension and source chosen per pass
            wr(CFG_ADDR, 8'h80 | 8'(sel) | 8'((k % 2) << 4));
            master_active = 1'b1;
            repeat (192) @(negedge core_clk);
            @(posedge core_clk) n = rs;
            repeat (960) @(negedge core_clk);
            @(posedge core_clk) n = rs - n;
            chk("bit rate", 8'h01, 8'(stretch_en ? n inside {[5:9]} : n inside {[8:11]}));
            chk("sda hold", 8'h01, 8'(mh >= (k % 2 ? 12 : 3)));
            chk("sda setup", 8'h01, 8'(ms >= (k % 2 ? 11 : 1)));
            @(negedge core_clk) master_active = 1'b0;
            repeat (200) @(negedge core_clk);
            transfer_end = 1'b1;
            @(negedge core_clk) transfer_end = 1'b0;
            rd(CFG_ADDR);
            chk("busy clear", 8'h80 | 8'(sel) | 8'((k % 2) << 4), v);
            $display("test source %0d done", k);
        end
        // Pending start waits over ten idle source periods
        sel = 1;
        per = 8;
        start_pending = 1'b1;
        wr(CFG_ADDR, 8'h85);
        scl_hold = 1'b1;
        repeat (10) @(negedge core_clk);
        scl_hold = 1'b0;
        n = 0;
        while (start_go !== 1'b1 && n < 400) begin
            @(negedge core_clk);
            n++;
        end
        chk("free wait", 8'h01, 8'(n inside {[81:96]}));
        rd(CFG_ADDR);
        chk("free busy", 8'h85, v);
        $display("test free timeout done");
        stop_test();
    end
endmodule : sbus_timing_tb
